/* src/dcc_mode_decode.sv */
// Mode decoder for the dual comparator control block.
// Purely combinational; the caller registers the result before it leaves.
`timescale 1ns/1ps

module dcc_mode_decode
  import dcc_pkg::*;
(
  input wire dcc_pkg::dcc_ctrl_t ctrl,
  output dcc_pkg::dcc_route_t route
);

  // ----------------------------------------------------------------------
  // Input selection per mode
  // ----------------------------------------------------------------------
  // Selector codes are port A pin numbers; 7 means not connected.
  always_comb begin
    route = '0;
    route.c1_neg_sel = 3'h7;
    route.c1_pos_sel = 3'h7;
    route.c2_neg_sel = 3'h7;
    route.c2_pos_sel = 3'h7;
    unique case (ctrl.mode)
      DCC_MODE_0, DCC_MODE_OFF: begin
        route.c1_on = 1'b0;
      end
      DCC_MODE_1: begin
        route.c1_on = 1'b1;
        route.c1_neg_sel = 3'h0;
        route.c1_pos_sel = 3'h3;
      end
      DCC_MODE_2, DCC_MODE_3: begin
        route.c1_on = 1'b1;
        route.c2_on = 1'b1;
        route.c1_neg_sel = 3'h0;
        route.c1_pos_sel = 3'h3;
        route.c2_neg_sel = 3'h1;
        route.c2_pos_sel = 3'h2;
        route.out_route = (ctrl.mode == DCC_MODE_3);
      end
      DCC_MODE_4: begin
        route.c1_on = 1'b1;
        route.c2_on = 1'b1;
        route.c1_neg_sel = 3'h0;
        route.c1_pos_sel = 3'h2;
        route.c2_neg_sel = 3'h1;
        route.c2_pos_sel = 3'h2;
      end
      DCC_MODE_5: begin
        route.c1_on = 1'b1;
        route.c2_on = 1'b1;
        route.c1_neg_sel = 3'h0;
        route.c1_pos_sel = 3'h2;
        route.c2_neg_sel = 3'h1;
        route.c2_pos_sel = 3'h2;
        route.out_route = 1'b1;
      end
      DCC_MODE_MUX4: begin
        route.c1_on = 1'b1;
        route.c2_on = 1'b1;
        route.ref_pos = 1'b1;
        route.c1_neg_sel = ctrl.sw ? 3'h3 : 3'h0;
        route.c2_neg_sel = ctrl.sw ? 3'h2 : 3'h1;
      end
    endcase
  end

endmodule

/* src/dcc_pkg.sv */
// Package for the dual comparator control block: register map, field layout,
// reset values and the carrier structs shared by the design files.
// Assumes an 8-bit register port with one-cycle strobes.
package dcc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0] DCC_ADDR_CTRL = 4'h0;
  localparam logic [3:0] DCC_ADDR_FLAG = 4'h1;
  localparam logic [3:0] DCC_ADDR_ENAB = 4'h2;
  localparam logic [3:0] DCC_ADDR_INTC = 4'h3;
  localparam logic [3:0] DCC_ADDR_DIRA = 4'h4;
  localparam logic [3:0] DCC_ADDR_PORTA = 4'h5;
  localparam logic [3:0] DCC_ADDR_IRQS = 4'h6;
  localparam logic [3:0] DCC_ADDR_IRQM = 4'h7;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int DCC_BIT_COMPARATOR2_OUTPUT_STATUS = 7;
  localparam int DCC_BIT_COMPARATOR1_OUTPUT_STATUS = 6;
  localparam int DCC_BIT_COMPARATOR2_POLARITY_INVERT = 5;
  localparam int DCC_BIT_COMPARATOR1_POLARITY_INVERT = 4;
  localparam int DCC_BIT_SWITCH = 3;
  localparam int DCC_BIT_CHGFLAG = 6;
  localparam int DCC_BIT_CHGEN = 6;
  localparam int DCC_BIT_GIE = 7;
  localparam int DCC_BIT_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int DCC_STAT_CHANGE = 0;
  localparam int DCC_STAT_MISMATCH = 1;

  // ----------------------------------------------------------------------
  // Reset values and modes
  // ----------------------------------------------------------------------
  localparam logic [7:0] DCC_CTRL_RESET = 8'h07;
  localparam logic [7:0] DCC_ZERO8 = 8'h00;
  localparam logic [5:0] DCC_DIRA_RESET = 6'h3F;
  localparam logic [1:0] DCC_STAT_RESET = 2'h0;

  typedef enum logic [2:0] {
    DCC_MODE_0 = 3'b000,
    DCC_MODE_1 = 3'b001,
    DCC_MODE_2 = 3'b010,
    DCC_MODE_3 = 3'b011,
    DCC_MODE_4 = 3'b100,
    DCC_MODE_5 = 3'b101,
    DCC_MODE_MUX4 = 3'b110,
    DCC_MODE_OFF = 3'b111
  } dcc_mode_t;

  // Writable part of the comparator control register.
  typedef struct packed {
    logic inv2;
    logic inv1;
    logic sw;
    dcc_mode_t mode;
  } dcc_ctrl_t;

  // Analog front end steering: source for each comparator input.
  typedef struct packed {
    logic ref_pos;
    logic [2:0] c1_neg_sel;
    logic [2:0] c1_pos_sel;
    logic [2:0] c2_neg_sel;
    logic [2:0] c2_pos_sel;
    logic c1_on;
    logic c2_on;
    logic out_route;
  } dcc_route_t;

  // Register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dcc_bus_t;

endpackage

/* src/dcc_top.sv */
// Dual comparator control: control register, output status, pin routing,
// change flag and interrupt gating around two analog comparators.
// Assumes raw comparator results arrive as plain levels, and a register port
// with one-cycle read and write strobes and read data one cycle later.
`timescale 1ns/1ps

module dcc_top
  import dcc_pkg::*;
#(
  parameter int PORT_W = 6
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic cmp1_raw,
  input wire logic cmp2_raw,
  input wire logic [PORT_W-1:0] port_a_pin_in,
  input wire logic [PORT_W-1:0] port_a_analog,
  output dcc_pkg::dcc_route_t afe_route,
  output logic port_a_pin5_out,
  output logic port_a_pin5_oe,
  output logic port_b_pin5_out,
  output logic port_b_pin5_oe,
  output logic cmp_irq_req,
  output logic irq
);
  import dcc_pkg::*;

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  dcc_ctrl_t ctrl_r;
  logic chg_flag_r;
  logic chg_en_r;
  logic gie_r;
  logic peripheral_irq_enable_r;
  logic [PORT_W-1:0] port_a_direction_r;
  logic [1:0] stat_r;
  logic [1:0] stat_mask_r;
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic [1:0] ref_out_r;
  dcc_route_t route_nxt;
  dcc_route_t route_r;
  logic [7:0] rdata_nxt;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // One function serves both strobe decoders so read and write agree.
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  wire wr_ctrl = reg_wr && hit(reg_addr, DCC_ADDR_CTRL);
  wire rd_ctrl = reg_rd && hit(reg_addr, DCC_ADDR_CTRL);
  wire wr_flag = reg_wr && hit(reg_addr, DCC_ADDR_FLAG);
  wire wr_enab = reg_wr && hit(reg_addr, DCC_ADDR_ENAB);
  wire wr_intc = reg_wr && hit(reg_addr, DCC_ADDR_INTC);
  wire wr_dira = reg_wr && hit(reg_addr, DCC_ADDR_DIRA);
  wire wr_irqs = reg_wr && hit(reg_addr, DCC_ADDR_IRQS);
  wire wr_irqm = reg_wr && hit(reg_addr, DCC_ADDR_IRQM);
  wire ctrl_access = wr_ctrl || rd_ctrl;

  // ----------------------------------------------------------------------
  // Output path
  // ----------------------------------------------------------------------
  // Raw result polarity.
  // The front end reports high when its positive input is above the negative.
  wire [1:0] raw_vec = {cmp2_raw, cmp1_raw};
  wire [1:0] inv_vec = {ctrl_r.inv2, ctrl_r.inv1};
  wire [1:0] on_vec = {route_r.c2_on, route_r.c1_on};

  // Polarity inversion applied.
  // Unsynchronized path feeds pins; an off comparator reads as its invert bit.
  wire [1:0] pin_cmp = (raw_vec & on_vec) ^ inv_vec;
  wire [1:0] stat_cmp = (sync2_r & on_vec) ^ inv_vec;

  wire mismatch = (stat_cmp != ref_out_r);
  wire flag_wr_val = reg_wdata[DCC_BIT_CHGFLAG];

  wire req_nxt = chg_flag_r && chg_en_r && peripheral_irq_enable_r && gie_r;

  wire [PORT_W-1:0] port_a_view = port_a_pin_in & ~port_a_analog;

  wire [7:0] ctrl_view = {stat_cmp, ctrl_r};

  // ----------------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_nxt = DCC_ZERO8;
    unique case (reg_addr)
      DCC_ADDR_CTRL: rdata_nxt = ctrl_view;
      DCC_ADDR_FLAG: rdata_nxt[DCC_BIT_CHGFLAG] = chg_flag_r;
      DCC_ADDR_ENAB: rdata_nxt[DCC_BIT_CHGEN] = chg_en_r;
      DCC_ADDR_INTC: rdata_nxt = {gie_r, peripheral_irq_enable_r, 6'h00};
      DCC_ADDR_DIRA: rdata_nxt[PORT_W-1:0] = port_a_direction_r;
      DCC_ADDR_PORTA: rdata_nxt[PORT_W-1:0] = port_a_view;
      DCC_ADDR_IRQS: rdata_nxt[1:0] = stat_r;
      DCC_ADDR_IRQM: rdata_nxt[1:0] = stat_mask_r;
      default: rdata_nxt = DCC_ZERO8;
    endcase
  end

  dcc_mode_decode u_decode (
    .ctrl(ctrl_r),
    .route(route_nxt)
  );

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  // Reset turns comparators off.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_r <= dcc_ctrl_t'(DCC_CTRL_RESET[5:0]);
    end else if (wr_ctrl) begin
      ctrl_r <= dcc_ctrl_t'(reg_wdata[5:0]);
    end
  end

  // Enable, direction and mask registers.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      chg_en_r <= 1'b0;
      gie_r <= 1'b0;
      peripheral_irq_enable_r <= 1'b0;
      port_a_direction_r <= DCC_DIRA_RESET;
      stat_mask_r <= DCC_STAT_RESET;
    end else begin
      if (wr_enab) chg_en_r <= reg_wdata[DCC_BIT_CHGEN];
      if (wr_intc) gie_r <= reg_wdata[DCC_BIT_GIE];
      if (wr_intc) peripheral_irq_enable_r <= reg_wdata[DCC_BIT_PERIPHERAL_IRQ_ENABLE];
      if (wr_dira) port_a_direction_r <= reg_wdata[PORT_W-1:0];
      if (wr_irqm) stat_mask_r <= reg_wdata[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Synchronizer and reference latch
  // ----------------------------------------------------------------------
  // Two-stage synchronizer.
  // Only the second stage is read; the first may be metastable.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
    end else begin
      sync1_r <= raw_vec;
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ref_out_r <= 2'h0;
    end else if (ctrl_access) begin
      ref_out_r <= stat_cmp;
    end
  end

  // ----------------------------------------------------------------------
  // Change flag
  // ----------------------------------------------------------------------
  // Write zero clears, one sets.
  // Mismatch beats a clear.
  // A clear in the same cycle as a mismatch loses so no change is dropped.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      chg_flag_r <= 1'b0;
    end else if (mismatch) begin
      chg_flag_r <= 1'b1;
    end else if (wr_flag) begin
      chg_flag_r <= flag_wr_val;
    end
  end

  // ----------------------------------------------------------------------
  // Sticky status, one-to-clear, with set winning
  // ----------------------------------------------------------------------
  // Both status bits come from the same mismatch event, so neither can miss a change.
  wire [1:0] stat_set = {mismatch, mismatch};
  wire [1:0] stat_clr = wr_irqs ? reg_wdata[1:0] : 2'h0;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stat_r <= DCC_STAT_RESET;
    end else begin
      stat_r <= (stat_r & ~stat_clr) | stat_set;
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  // Routed pins use raw outputs.
  // Direction bits gate pins.
  // The pin copy adds one flop of delay; the value itself is unsynchronized.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= DCC_ZERO8;
      route_r <= '0;
      afe_route <= '0;
      port_a_pin5_out <= 1'b0;
      port_a_pin5_oe <= 1'b0;
      port_b_pin5_out <= 1'b0;
      port_b_pin5_oe <= 1'b0;
      cmp_irq_req <= 1'b0;
      irq <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rdata_nxt : DCC_ZERO8;
      route_r <= route_nxt;
      afe_route <= route_nxt;
      port_a_pin5_out <= pin_cmp[0];
      port_a_pin5_oe <= route_r.out_route && !port_a_direction_r[5];
      port_b_pin5_out <= pin_cmp[1];
      port_b_pin5_oe <= route_r.out_route && !port_a_direction_r[4];
      cmp_irq_req <= req_nxt;
      irq <= |(stat_r & stat_mask_r);
    end
  end

endmodule

/* test/dcc_afe_model.sv */
// Behavioural model of the two analog comparator front ends.
// Assumes steering from dcc_top and pin voltages as bytes, pin 0 lowest.
`timescale 1ns/1ps
module dcc_afe_model
  import dcc_pkg::*;
(
  input wire dcc_pkg::dcc_route_t afe_route,
  input wire logic [47:0] vin,
  input wire logic [7:0] vref,
  output logic cmp1_raw,
  output logic cmp2_raw
);
  // An unselected input, code 7 or beyond the port, reads as ground.
  function automatic logic [7:0] pick(input logic [2:0] s);
    pick = (s < 3'h6) ? vin[{s, 3'h0} +: 8] : 8'h00;
  endfunction
  wire logic [7:0] p1 = afe_route.ref_pos ? vref : pick(afe_route.c1_pos_sel);
  wire logic [7:0] p2 = afe_route.ref_pos ? vref : pick(afe_route.c2_pos_sel);
  // high when positive wins; an off comparator idles low.
  assign cmp1_raw = afe_route.c1_on && (p1 > pick(afe_route.c1_neg_sel));
  assign cmp2_raw = afe_route.c2_on && (p2 > pick(afe_route.c2_neg_sel));
endmodule

/* test/dcc_monitor.sv */
// Port-level assertions for the dual comparator control block.
// Assumes it is bound to dcc_top and sees only that module's ports.
`timescale 1ns/1ps
module dcc_monitor
  import dcc_pkg::*;
#(
  parameter int PORT_W = 6
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic cmp1_raw,
  input wire logic cmp2_raw,
  input wire logic [PORT_W-1:0] port_a_pin_in,
  input wire logic [PORT_W-1:0] port_a_analog,
  input wire dcc_pkg::dcc_route_t afe_route,
  input wire logic port_a_pin5_out,
  input wire logic port_a_pin5_oe,
  input wire logic port_b_pin5_out,
  input wire logic port_b_pin5_oe,
  input wire logic cmp_irq_req,
  input wire logic irq
);
  logic [5:0] sh_r;
  logic [2:0] quiet_r;
  logic [2:0] age_r;
  logic raw_d_r;
  wire logic ctrl_wr = reg_wr && reg_addr == DCC_ADDR_CTRL;
  // Shadow of the control bits and settle counters; outputs lag by a few flops.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sh_r <= 6'h07;
      quiet_r <= 3'h0;
      age_r <= 3'h0;
    end else begin
      sh_r <= ctrl_wr ? reg_wdata[5:0] : sh_r;
      quiet_r <= ctrl_wr ? 3'h0 : (quiet_r == 3'h7 ? quiet_r : quiet_r + 3'h1);
      age_r <= (cmp1_raw != raw_d_r) ? 3'h0 : (age_r == 3'h7 ? age_r : age_r + 3'h1);
    end
    raw_d_r <= cmp1_raw;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_rst_out: assert property ($fell(sys_rst) |-> reg_rdata == 8'h00 && !irq && !cmp_irq_req)
    else $error("outputs not clear after reset");
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_unmap: assert property (reg_rd && reg_addr[3] |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_rd: assert property (reg_rd && reg_addr == DCC_ADDR_CTRL |=> reg_rdata[5:0] == $past(sh_r))
    else $error("control readback wrong");
  a_stat1: assert property (reg_rd && reg_addr == DCC_ADDR_CTRL && afe_route.c1_on && quiet_r == 3'h7
    && age_r == 3'h7 |=> reg_rdata[6] == ($past(cmp1_raw) ^ $past(sh_r[4])))
    else $error("status bit 6 wrong");
  a_pin1: assert property (afe_route.out_route && quiet_r == 3'h7
    |-> port_a_pin5_out == ($past(cmp1_raw) ^ sh_r[4]))
    else $error("routed pin wrong");
  a_oe_dir: assert property (reg_wr && reg_addr == DCC_ADDR_DIRA && reg_wdata[5] |-> ##2 !port_a_pin5_oe)
    else $error("pin driven as input");
  a_oe_rt: assert property (quiet_r == 3'h7 && port_a_pin5_oe |-> afe_route.out_route)
    else $error("pin driven without routing");
  a_gate: assert property (reg_wr && reg_addr == DCC_ADDR_INTC && reg_wdata[7:6] != 2'h3
    |-> ##2 !cmp_irq_req)
    else $error("request without enables");
  a_mask: assert property (reg_wr && reg_addr == DCC_ADDR_IRQM && reg_wdata == 8'h00 |-> ##2 !irq)
    else $error("masked interrupt raised");
endmodule
bind dcc_top dcc_monitor #(.PORT_W(PORT_W)) dcc_monitor_i (.mclk(mclk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .cmp1_raw(cmp1_raw), .cmp2_raw(cmp2_raw),
  .port_a_pin_in(port_a_pin_in), .port_a_analog(port_a_analog), .afe_route(afe_route),
  .port_a_pin5_out(port_a_pin5_out), .port_a_pin5_oe(port_a_pin5_oe),
  .port_b_pin5_out(port_b_pin5_out), .port_b_pin5_oe(port_b_pin5_oe),
  .cmp_irq_req(cmp_irq_req), .irq(irq));

/* test/dcc_tb_top.sv */
// Self-checking testbench for the dual comparator control block.
// Assumes dcc_top, the front end model and the bound checker are compiled.
`timescale 1ns/1ps
`define CHK(g, e) chk(8'(g), 8'(e))
module dual_comparator_control_tb_top;
  import dcc_pkg::*;
  logic mclk, sys_rst, reg_wr, reg_rd, c1, c2, pa_out, pa_oe, pb_out, pb_oe, irq_req, irq;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, vref;
  logic [47:0] vin;
  logic [5:0] pin_in, analog;
  dcc_route_t route;
  int n_errors, n_checks;
  dcc_top #(.PORT_W(6)) dcc_top_i (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmp1_raw(c1), .cmp2_raw(c2), .port_a_pin_in(pin_in), .port_a_analog(analog),
    .afe_route(route), .port_a_pin5_out(pa_out), .port_a_pin5_oe(pa_oe),
    .port_b_pin5_out(pb_out), .port_b_pin5_oe(pb_oe), .cmp_irq_req(irq_req), .irq(irq));
  dcc_afe_model dcc_afe_model_i (.afe_route(route), .vin(vin), .vref(vref), .cmp1_raw(c1),
    .cmp2_raw(c2));
  // Free-running 25 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just there.
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e);
  endtask
  task w(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task close_out();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog: the tests need well under 2000 cycles.
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
  // Main test sequence.
  initial begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    vin = 48'h0000_C040_C040;
    vref = 8'h80;
    pin_in = 6'h3F;
    analog = 6'h0F;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(DCC_ADDR_CTRL, 8'h07);
    rd(DCC_ADDR_DIRA, 8'h3F);
    rd(4'h9, 8'h00);
    rd(DCC_ADDR_PORTA, 8'h30);
    $display("test reset done");
    for (int m = 0; m < 8; m++) begin
      wr(DCC_ADDR_CTRL, 8'(m));
      w(3);
      `CHK(route.ref_pos, m == 6);
    end
    `CHK(route.c1_on | route.c2_on, 0);
    wr(DCC_ADDR_CTRL, 8'h06);
    w(6);
    rd(DCC_ADDR_CTRL, 8'h46);
    wr(DCC_ADDR_CTRL, 8'h0E);
    w(6);
    `CHK(route.c1_neg_sel, 3);
    rd(DCC_ADDR_CTRL, 8'h8E);
    wr(DCC_ADDR_CTRL, 8'hFE);
    w(6);
    rd(DCC_ADDR_CTRL, 8'h7E);
    wr(DCC_ADDR_CTRL, 8'h06);
    w(6);
    $display("test modes done");
    wr(DCC_ADDR_ENAB, 8'h40);
    wr(DCC_ADDR_INTC, 8'hC0);
    wr(DCC_ADDR_IRQM, 8'h01);
    rd(DCC_ADDR_CTRL, 8'h46);
    wr(DCC_ADDR_FLAG, 8'h00);
    wr(DCC_ADDR_IRQS, 8'h03);
    rd(DCC_ADDR_FLAG, 8'h00);
    vin[7:0] = 8'hF0;
    w(6);
    rd(DCC_ADDR_FLAG, 8'h40);
    `CHK(irq_req, 1);
    `CHK(irq, 1);
    rd(DCC_ADDR_IRQS, 8'h03);
    wr(DCC_ADDR_IRQM, 8'h00);
    w(2);
    `CHK(irq, 0);
    wr(DCC_ADDR_FLAG, 8'h00);
    rd(DCC_ADDR_FLAG, 8'h40);
    rd(DCC_ADDR_CTRL, 8'h06);
    wr(DCC_ADDR_FLAG, 8'h00);
    rd(DCC_ADDR_FLAG, 8'h00);
    w(2);
    `CHK(irq_req, 0);
    wr(DCC_ADDR_FLAG, 8'h40);
    rd(DCC_ADDR_FLAG, 8'h40);
    for (int i = 0; i < 3; i++) begin
      wr(DCC_ADDR_ENAB, (i == 0) ? 8'h00 : 8'h40);
      wr(DCC_ADDR_INTC, {i != 2, i != 1, 6'h00});
      w(2);
      `CHK(irq_req, 0);
      rd(DCC_ADDR_FLAG, 8'h40);
    end
    $display("test interrupts done");
    wr(DCC_ADDR_DIRA, 8'h0F);
    // Mask the change interrupt before the mode change, as software should.
    wr(DCC_ADDR_ENAB, 8'h00);
    wr(DCC_ADDR_CTRL, 8'h13);
    w(6);
    `CHK({pa_oe, pb_oe}, 2'h3);
    `CHK({pa_out, pb_out}, {~c1, c2});
    vin = ~vin;
    w(1);
    `CHK({pa_out, pb_out}, {~c1, c2});
    wr(DCC_ADDR_DIRA, 8'h3F);
    w(2);
    `CHK({pa_oe, pb_oe}, 2'h0);
    $display("test routing done");
    sys_rst <= 1'b1;
    w(2);
    sys_rst <= 1'b0;
    rd(DCC_ADDR_CTRL, 8'h07);
    rd(DCC_ADDR_FLAG, 8'h00);
    $display("test second reset done");
    close_out();
  end
endmodule
